// ### hw/bit_sync.sv
// two flip-flop level synchroniser for a vector of independent bits
`timescale 1ns/1ns
module bit_sync #(
   parameter int W = 1
)(
   // clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_nrst,
   // asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   logic [W-1:0] meta;

   // ---------------------------------------------------------------------
   // one pair of flops per bit
   // ---------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1)
      begin : g_bit
         always_ff @(posedge i_clk or negedge i_nrst)
         begin
            if (!i_nrst)
            begin
               meta[g] <= 1'b0;
               o_q[g]  <= 1'b0;
            end
            else
            begin
               meta[g] <= i_d[g];
               o_q[g]  <= meta[g];
            end
         end
      end
   endgenerate

endmodule

// ### hw/cfg_port_pkg.sv
// types shared by the serial config port
package cfg_port_pkg;

   // ---------------------------------------------------------------------
   // link state machine
   // ---------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_WR,
      ST_ACK_WAIT,
      ST_ACK,
      ST_RD,
      ST_RD_ACK,
      ST_RD_NEXT
   } link_state_t;

endpackage

// ### hw/cfg_port_regs.svh
// byte map, reset values and address fields of the serial config port
`ifndef CFG_PORT_REGS_SVH
`define CFG_PORT_REGS_SVH

// ----------------------------------------------------------------------
// register byte indexes
// ----------------------------------------------------------------------
`define CFG_NUM_BYTES   4'hC
`define IDX_SIG_DETECT  4'h0
`define IDX_RSVD_RO     4'h1
`define IDX_LOOP_EMPH   4'h2
`define IDX_IN_DISABLE  4'h3
`define IDX_OUT_DISABLE 4'h4
`define IDX_RSVD_RW5    4'h5
`define IDX_POWER       4'h6
`define IDX_RSVD_RW7    4'h7
`define IDX_A_CHAN      4'h8
`define IDX_B_CHAN      4'h9
`define IDX_TEST_LO     4'hA
`define IDX_TEST_HI     4'hB

// ----------------------------------------------------------------------
// reset values and writable bit masks
// ----------------------------------------------------------------------
`define RST_LOOP_EMPH   8'hFC
`define RST_IN_DISABLE  8'h00
`define RST_OUT_DISABLE 8'h00
`define RST_RSVD_RW     8'h00
`define RST_POWER       8'hFF
`define RST_A_CHAN      8'hFF
`define RST_B_CHAN      8'hFF
`define RST_TEST_LO     8'h00
`define RST_TEST_HI     8'hEF
`define RST_NONE        8'h00
`define WMASK_LOOP_EMPH 8'hFC
`define WMASK_FULL      8'hFF
`define WMASK_NONE      8'h00

// ----------------------------------------------------------------------
// slave address fields (bits 7..1 of the address byte)
// ----------------------------------------------------------------------
`define ADDR_TOP_BITS   2'h3
`define ADDR_MID_BITS   2'h0
`define BIT_LAST        3'h7

`endif

// ### hw/i2c_config_slave_port.sv
// two-wire slave port holding the configuration bytes of the conditioner
`timescale 1ns/1ns
`include "cfg_port_regs.svh"

// Functional notes
// - eight bits then one acknowledge slot
// - every byte shifted most significant bit first
// - clock line is never driven low
// - every transfer starts at register byte zero
// - first written data byte acknowledged, discarded
// - seven address bits, low bit selects direction
// - address 11x00xx, three bits from straps
// - acknowledge holds data low through high phase
// - acknowledge address byte and every written byte
// - after start, compare next byte with address
// - data falling while clock high is start
// - data rising while clock high is stop
// - read-only bytes ignore writes, read current value
// - test byte ten resets zero, read/write
module i2c_config_slave_port
   import cfg_port_pkg::*;
(
   // system clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   // link sampling clock
   input  wire logic       i_link_clk,
   // serial clock pin
   input  wire logic       i_scl_i,
   output logic            o_scl_o,
   output logic            o_scl_oe,
   // serial data pin
   input  wire logic       i_sda_i,
   output logic            o_sda_o,
   output logic            o_sda_oe,
   // address strap pins
   input  wire logic       i_slave_sel_pin_high,
   input  wire logic       i_slave_sel_pin_mid,
   input  wire logic       i_slave_sel_pin_low,
   // live channel signal detect status
   input  wire logic [7:0] i_sig_detect,
   // configuration bytes towards the channel logic
   output logic      [7:0] o_loop_emph,
   output logic      [7:0] o_in_disable,
   output logic      [7:0] o_out_disable,
   output logic      [7:0] o_power_ctrl,
   output logic      [7:0] o_a_chan_ctrl,
   output logic      [7:0] o_b_chan_ctrl
);

   // ---------------------------------------------------------------------
   // decoding helpers
   // ---------------------------------------------------------------------

   // bits that software may change in each byte
   function automatic logic [7:0] wr_mask(input logic [3:0] idx);
      logic [7:0] m;
      m = `WMASK_FULL;
      if (idx == `IDX_SIG_DETECT || idx == `IDX_RSVD_RO)
         m = `WMASK_NONE;
      else if (idx == `IDX_LOOP_EMPH)
         m = `WMASK_LOOP_EMPH;
      else if (idx >= `CFG_NUM_BYTES)
         m = `WMASK_NONE;
      return m;
   endfunction

   // power-up contents of each byte
   function automatic logic [7:0] rst_val(input logic [3:0] idx);
      logic [7:0] v;
      v = `RST_NONE;
      case (idx)
         `IDX_LOOP_EMPH:   v = `RST_LOOP_EMPH;
         `IDX_IN_DISABLE:  v = `RST_IN_DISABLE;
         `IDX_OUT_DISABLE: v = `RST_OUT_DISABLE;
         `IDX_RSVD_RW5:    v = `RST_RSVD_RW;
         `IDX_POWER:       v = `RST_POWER;
         `IDX_RSVD_RW7:    v = `RST_RSVD_RW;
         `IDX_A_CHAN:      v = `RST_A_CHAN;
         `IDX_B_CHAN:      v = `RST_B_CHAN;
         `IDX_TEST_LO:     v = `RST_TEST_LO;
         `IDX_TEST_HI:     v = `RST_TEST_HI;
         default:          v = `RST_NONE;
      endcase
      return v;
   endfunction

   // address byte bits 7..1 against the fixed and strapped fields
   function automatic logic addr_match(input logic [7:0] b,
                                       input logic [2:0] strap);
      return (b[7:6] == `ADDR_TOP_BITS) &&
             (b[5] == strap[2]) &&
             (b[4:3] == `ADDR_MID_BITS) &&
             (b[2:1] == strap[1:0]);
   endfunction

   // ---------------------------------------------------------------------
   // link domain: pin synchronisers and bus condition detection
   // ---------------------------------------------------------------------
   logic [12:0] link_sync;
   logic        scl_s;
   logic        sda_s;
   logic [2:0]  strap_s;
   logic [7:0]  sig_s;
   logic        scl_d;
   logic        sda_d;

   bit_sync #(.W(13)) u_link_sync (
      .i_clk  (i_link_clk),
      .i_nrst (i_nrst),
      .i_d    ({~i_scl_i, ~i_sda_i, i_slave_sel_pin_high,
                i_slave_sel_pin_mid, i_slave_sel_pin_low, i_sig_detect}),
      .o_q    (link_sync)
   );

   // bus lines pass inverted so cleared flops read as an idle bus
   assign scl_s   = ~link_sync[12];
   assign sda_s   = ~link_sync[11];
   assign strap_s = link_sync[10:8];
   assign sig_s   = link_sync[7:0];

   // previous synchronised levels for edge detection
   always_ff @(posedge i_link_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign scl_rise  = scl_s & ~scl_d;
   assign scl_fall  = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

   // ---------------------------------------------------------------------
   // link domain: byte engine state
   // ---------------------------------------------------------------------
   link_state_t state;
   logic [2:0]  bit_cnt;
   logic [7:0]  rx_shift;
   logic [7:0]  rx_byte;
   logic [7:0]  tx_shift;
   logic [7:0]  rd_data;
   logic [3:0]  ptr;
   logic        dummy_pending;
   logic        rw_read;
   logic        byte_done;
   logic        wr_en;
   logic        wr_tgl;
   logic [7:0]  regs [0:11];

   // incoming byte completes on the eighth rising clock, msb first
   assign rx_byte   = {rx_shift[6:0], sda_s};
   assign byte_done = scl_rise && (bit_cnt == `BIT_LAST) &&
                      (state == ST_ADDR || state == ST_WR);
   assign wr_en     = byte_done && (state == ST_WR) &&
                      !dummy_pending;

   // sequencing of address, data and acknowledge slots
   always_ff @(posedge i_link_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state   <= ST_IDLE;
         bit_cnt <= 3'h0;
      end
      else if (start_det)
      begin
         state   <= ST_ADDR;
         bit_cnt <= 3'h0;
      end
      else if (stop_det)
         state <= ST_IDLE;
      else
      begin
         case (state)
            ST_IDLE: ;
            ST_ADDR:
            begin
               if (scl_rise)
                  bit_cnt <= bit_cnt + 3'h1;
               if (byte_done)
                  state <= addr_match(rx_byte, strap_s) ?
                           ST_ACK_WAIT : ST_IDLE;
            end
            ST_WR:
            begin
               if (scl_rise)
                  bit_cnt <= bit_cnt + 3'h1;
               if (byte_done)
                  state <= ST_ACK_WAIT;
            end
            ST_ACK_WAIT:
               if (scl_fall)
                  state <= ST_ACK;
            ST_ACK:
               if (scl_fall)
               begin
                  state   <= rw_read ? ST_RD : ST_WR;
                  bit_cnt <= 3'h0;
               end
            ST_RD:
               if (scl_fall)
               begin
                  if (bit_cnt == `BIT_LAST)
                     state <= ST_RD_ACK;
                  bit_cnt <= bit_cnt + 3'h1;
               end
            ST_RD_ACK:
               if (scl_rise)
                  state <= sda_s ? ST_IDLE : ST_RD_NEXT;
            ST_RD_NEXT:
               if (scl_fall)
               begin
                  state   <= ST_RD;
                  bit_cnt <= 3'h0;
               end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // receive shifter and captured direction bit
   always_ff @(posedge i_link_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rx_shift <= 8'h00;
         rw_read  <= 1'b0;
      end
      else
      begin
         if (scl_rise && (state == ST_ADDR || state == ST_WR))
            rx_shift <= rx_byte;
         if (byte_done && state == ST_ADDR)
            rw_read <= rx_byte[0];
      end
   end

   // byte pointer and dummy byte tracking
   always_ff @(posedge i_link_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ptr           <= 4'h0;
         dummy_pending <= 1'b1;
      end
      else if (start_det)
      begin
         ptr           <= 4'h0;
         dummy_pending <= 1'b1;
      end
      else if (byte_done && state == ST_WR)
      begin
         if (dummy_pending)
            dummy_pending <= 1'b0;
         else if (ptr != 4'hF)
            ptr <= ptr + 4'h1;
      end
      else if (state == ST_RD_ACK && scl_rise && !sda_s && ptr != 4'hF)
         ptr <= ptr + 4'h1;
   end

   // read data selection, live status in byte zero
   always_comb
   begin
      rd_data = 8'h00;
      if (ptr == `IDX_SIG_DETECT)
         rd_data = sig_s;
      else if (ptr < `CFG_NUM_BYTES)
         rd_data = regs[ptr];
   end

   // transmit shifter, loaded at the falling clock before each byte
   always_ff @(posedge i_link_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         tx_shift <= 8'h00;
      else if (scl_fall)
      begin
         if ((state == ST_ACK && rw_read) || state == ST_RD_NEXT)
            tx_shift <= rd_data;
         else if (state == ST_RD && bit_cnt != `BIT_LAST)
            tx_shift <= {tx_shift[6:0], 1'b0};
      end
   end

   // data line drive: acknowledge and read bits, released otherwise
   always_ff @(posedge i_link_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_sda_oe <= 1'b0;
      else if (start_det || stop_det)
         o_sda_oe <= 1'b0;
      else if (scl_fall)
      begin
         case (state)
            ST_ACK_WAIT:
               o_sda_oe <= 1'b1;
            ST_ACK:
               o_sda_oe <= rw_read & ~rd_data[7];
            ST_RD:
               o_sda_oe <= (bit_cnt == `BIT_LAST) ? 1'b0 :
                           ~tx_shift[6];
            ST_RD_NEXT:
               o_sda_oe <= ~rd_data[7];
            default:
               o_sda_oe <= 1'b0;
         endcase
      end
   end

   // open-drain levels; the clock line is never pulled
   always_ff @(posedge i_link_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_sda_o  <= 1'b0;
         o_scl_o  <= 1'b0;
         o_scl_oe <= 1'b0;
      end
      else
      begin
         o_sda_o  <= 1'b0;
         o_scl_o  <= 1'b0;
         o_scl_oe <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------
   // link domain: register bytes
   // ---------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 12; g = g + 1)
      begin : g_reg
         localparam logic [3:0] IDX = 4'(g);
         always_ff @(posedge i_link_clk or negedge i_nrst)
         begin
            if (!i_nrst)
               regs[g] <= rst_val(IDX);
            else if (wr_en && ptr == IDX)
               regs[g] <= (regs[g] & ~wr_mask(IDX)) |
                          (rx_byte & wr_mask(IDX));
         end
      end
   endgenerate

   // event toggle telling the system side that a byte was written
   always_ff @(posedge i_link_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         wr_tgl <= 1'b0;
      else if (wr_en)
         wr_tgl <= ~wr_tgl;
   end

   // ---------------------------------------------------------------------
   // system domain: copy the register bytes after each write
   // ---------------------------------------------------------------------
   logic wr_tgl_s;
   logic wr_tgl_d;

   bit_sync #(.W(1)) u_tgl_sync (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_d    (wr_tgl),
      .o_q    (wr_tgl_s)
   );

   // bytes are quiet for many link clocks after the toggle moves
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         wr_tgl_d      <= 1'b0;
         o_loop_emph   <= `RST_LOOP_EMPH;
         o_in_disable  <= `RST_IN_DISABLE;
         o_out_disable <= `RST_OUT_DISABLE;
         o_power_ctrl  <= `RST_POWER;
         o_a_chan_ctrl <= `RST_A_CHAN;
         o_b_chan_ctrl <= `RST_B_CHAN;
      end
      else
      begin
         wr_tgl_d <= wr_tgl_s;
         if (wr_tgl_s != wr_tgl_d)
         begin
            o_loop_emph   <= regs[`IDX_LOOP_EMPH];
            o_in_disable  <= regs[`IDX_IN_DISABLE];
            o_out_disable <= regs[`IDX_OUT_DISABLE];
            o_power_ctrl  <= regs[`IDX_POWER];
            o_a_chan_ctrl <= regs[`IDX_A_CHAN];
            o_b_chan_ctrl <= regs[`IDX_B_CHAN];
         end
      end
   end

endmodule

// ### testbench/i2c_bus_master_model.sv
// behavioural two-wire bus master clocked by the link clock
`timescale 1ns/1ns
module i2c_bus_master_model (
   // link clock
   input  wire logic i_link_clk,
   // data wire level
   input  wire logic i_sda,
   // clock line and data pull-down
   output logic      o_scl,
   output logic      o_sda_low
);
   // idle bus: clock high, data released
   initial
   begin
      o_scl     = 1'b1;
      o_sda_low = 1'b0;
   end

   task automatic w(input int n);
      repeat (n) @(posedge i_link_clk);
   endtask

   // one bit: data set while clock low, sampled mid high phase
   task automatic bit_slot(input logic b, output logic r);
      w(2);
      o_sda_low <= !b;
      w(5);
      o_scl <= 1'b1;
      w(4);
      r = i_sda;
      w(3);
      o_scl <= 1'b0;
   endtask

   // start or repeated start: data falls while clock high
   task automatic start_cond;
      w(2);
      o_sda_low <= 1'b0;
      w(5);
      o_scl <= 1'b1;
      w(6);
      o_sda_low <= 1'b1;
      w(6);
      o_scl <= 1'b0;
   endtask

   // stop: data rises while clock high, clock then stands high
   task automatic stop_cond;
      w(2);
      o_sda_low <= 1'b1;
      w(5);
      o_scl <= 1'b1;
      w(6);
      o_sda_low <= 1'b0;
      w(6);
   endtask

   // eight bits msb first, then the acknowledge slot
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_slot(d[i], r);
      bit_slot(1'b1, r);
      ack = !r;
   endtask

   // eight bits in, then our own acknowledge or nack
   task automatic get_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_slot(1'b1, d[i]);
      bit_slot(!ack, r);
   endtask
endmodule

// ### testbench/i2c_config_slave_port_properties.sv
// bus-level assertions for the serial config port
`timescale 1ns/1ns
module i2c_config_slave_port_properties (
   // link clock and reset
   input  wire logic i_link_clk,
   input  wire logic i_nrst,
   // bus pins
   input  wire logic i_scl_i,
   input  wire logic i_sda_i,
   input  wire logic o_scl_o,
   input  wire logic o_scl_oe,
   input  wire logic o_sda_o,
   input  wire logic o_sda_oe,
   // address straps
   input  wire logic i_slave_sel_pin_high,
   input  wire logic i_slave_sel_pin_mid,
   input  wire logic i_slave_sel_pin_low
);
   logic       scl_q;
   logic       sda_q;
   logic       active;
   logic       first;
   logic       hit;
   logic       rd;
   logic       nacked;
   logic [3:0] nbit;
   logic [7:0] shreg;
   logic [6:0] own;
   logic       slot;
   logic       start_ev;
   logic       stop_ev;

   // ------------------------------------------------------------------
   // frame tracking at the pins
   // ------------------------------------------------------------------
   // own address, bus conditions and the acknowledge slot rise
   assign own = {2'h3, i_slave_sel_pin_high, 2'h0, i_slave_sel_pin_mid,
                 i_slave_sel_pin_low};
   assign start_ev = scl_q && i_scl_i && sda_q && !i_sda_i;
   assign stop_ev  = scl_q && i_scl_i && !sda_q && i_sda_i;
   assign slot     = i_scl_i && !scl_q && (nbit == 4'h8);

   // previous pin levels
   always_ff @(posedge i_link_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= i_scl_i;
         sda_q <= i_sda_i;
      end
   end

   // bit count, address match, direction and master nack
   always_ff @(posedge i_link_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         active <= 1'b0;
         first  <= 1'b0;
         hit    <= 1'b0;
         rd     <= 1'b0;
         nacked <= 1'b0;
         nbit   <= 4'h0;
         shreg  <= 8'h00;
      end
      else if (start_ev)
      begin
         active <= 1'b1;
         first  <= 1'b1;
         nacked <= 1'b0;
         nbit   <= 4'h0;
      end
      else if (stop_ev)
         active <= 1'b0;
      else if (i_scl_i && !scl_q)
      begin
         shreg <= {shreg[6:0], i_sda_i};
         nbit  <= slot ? 4'h0 : nbit + 4'h1;
         if (slot && first)
         begin
            hit <= (shreg[7:1] == own);
            rd  <= shreg[0];
         end
         if (slot)
            first <= 1'b0;
         if (slot && !first && rd && i_sda_i)
            nacked <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_link_clk);
   endclocking
   default disable iff (!i_nrst);

   sequence start_seq;
      start_ev;
   endsequence
   sequence stop_seq;
      stop_ev;
   endsequence

   a_scl_never_driven: assert property (
         !o_scl_oe && !o_scl_o)
      else $error("clock line driven");
   a_sda_open_drain: assert property (o_sda_oe |-> !o_sda_o)
      else $error("data line driven high");
   a_steady_scl_high: assert property (
         i_scl_i && scl_q |-> $stable(o_sda_oe))
      else $error("data changed while clock high");
   a_ack_own_addr: assert property (
         slot && first && shreg[7:1] == own |-> o_sda_oe)
      else $error("own address not acknowledged");
   a_nack_other_addr: assert property (
         slot && first && shreg[7:1] != own |-> !o_sda_oe)
      else $error("foreign address acknowledged");
   a_ack_write_bytes: assert property (
         slot && !first && hit && !rd |-> o_sda_oe)
      else $error("written byte not acknowledged");
   a_read_slot_free: assert property (
         slot && !first && hit && rd |-> !o_sda_oe)
      else $error("read acknowledge slot driven");
   a_ignore_mismatch: assert property (
         active && !first && !hit |-> !o_sda_oe)
      else $error("data driven after mismatch");
   a_quiet_after_nack: assert property (
         active && nacked |-> !o_sda_oe)
      else $error("data driven after master nack");
   a_start_no_drive: assert property (start_seq |-> !o_sda_oe [*8])
      else $error("data driven after start");
   a_stop_released: assert property (stop_seq |-> !o_sda_oe [*4])
      else $error("data driven after stop");
endmodule

bind i2c_config_slave_port i2c_config_slave_port_properties u_props (
   .i_link_clk          (i_link_clk),
   .i_nrst              (i_nrst),
   .i_scl_i             (i_scl_i),
   .i_sda_i             (i_sda_i),
   .o_scl_o             (o_scl_o),
   .o_scl_oe            (o_scl_oe),
   .o_sda_o             (o_sda_o),
   .o_sda_oe            (o_sda_oe),
   .i_slave_sel_pin_high(i_slave_sel_pin_high),
   .i_slave_sel_pin_mid (i_slave_sel_pin_mid),
   .i_slave_sel_pin_low (i_slave_sel_pin_low)
);

// ### testbench/i2c_config_slave_port_test.sv
// self-checking bench for the serial config port
`timescale 1ns/1ns
module i2c_config_slave_port_test;
   logic       i_clk;
   logic       i_link_clk;
   logic       i_nrst;
   logic       m_scl;
   logic       m_sda_low;
   wire        scl;
   wire        sda;
   logic [2:0] strap;
   logic [7:0] sig;
   logic       sda_oe;
   logic       scl_oe;
   logic [7:0] outs [6];
   logic [7:0] mem [12];
   logic [6:0] own;
   int         err_total;
   int         cmp_count;
   int         oi [6] = '{2, 3, 4, 6, 8, 9};

   // ------------------------------------------------------------------
   // clocks, wires and instances
   // ------------------------------------------------------------------
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = !i_clk;
   end
   initial
   begin
      i_link_clk = 1'b0;
      #7;
      forever #16 i_link_clk = !i_link_clk;
   end

   // pulled-up open-drain lines
   assign sda = !(m_sda_low || sda_oe);
   assign scl = m_scl && !scl_oe;
   assign own = {2'h3, strap[2], 2'h0, strap[1:0]};

   i2c_config_slave_port u_dut (
      .i_clk               (i_clk),
      .i_nrst              (i_nrst),
      .i_link_clk          (i_link_clk),
      .i_scl_i             (scl),
      .o_scl_o             (),
      .o_scl_oe            (scl_oe),
      .i_sda_i             (sda),
      .o_sda_o             (),
      .o_sda_oe            (sda_oe),
      .i_slave_sel_pin_high(strap[2]),
      .i_slave_sel_pin_mid (strap[1]),
      .i_slave_sel_pin_low (strap[0]),
      .i_sig_detect        (sig),
      .o_loop_emph         (outs[0]),
      .o_in_disable        (outs[1]),
      .o_out_disable       (outs[2]),
      .o_power_ctrl        (outs[3]),
      .o_a_chan_ctrl       (outs[4]),
      .o_b_chan_ctrl       (outs[5])
   );

   i2c_bus_master_model u_master (
      .i_link_clk(i_link_clk),
      .i_sda     (sda),
      .o_scl     (m_scl),
      .o_sda_low (m_sda_low)
   );

   // ------------------------------------------------------------------
   // compare tasks and expectations
   // ------------------------------------------------------------------
   task automatic chk8(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask

   // value a byte holds after a write of v
   function automatic logic [7:0] stored(input int i, input logic [7:0] v);
      stored = (i < 2) ? mem[i] : (i == 2) ? (v & 8'hFC) : v;
   endfunction

   function automatic logic [7:0] read_exp(input int i);
      read_exp = (i == 0) ? sig : (i < 12) ? mem[i] : 8'h00;
   endfunction

   task automatic chk_outs;
      repeat (8) @(posedge i_clk);
      for (int k = 0; k < 6; k++)
         chk8("config output", mem[oi[k]], outs[k]);
   endtask

   // ------------------------------------------------------------------
   // bus sequences
   // ------------------------------------------------------------------
   task automatic wr_seq(input int n, input logic fin);
      logic       ack;
      logic [7:0] d;
      u_master.start_cond();
      u_master.put_byte({own, 1'b0}, ack);
      chk1("write address ack", 1'b1, ack);
      u_master.put_byte(8'($urandom), ack);
      chk1("dummy ack", 1'b1, ack);
      for (int i = 0; i < n; i++)
      begin
         d = 8'($urandom);
         u_master.put_byte(d, ack);
         chk1("data ack", 1'b1, ack);
         if (i < 12)
            mem[i] = stored(i, d);
      end
      if (fin)
         u_master.stop_cond();
   endtask

   task automatic rd_seq(input int n);
      logic       ack;
      logic [7:0] d;
      u_master.start_cond();
      u_master.put_byte({own, 1'b1}, ack);
      chk1("read address ack", 1'b1, ack);
      for (int i = 0; i < n; i++)
      begin
         u_master.get_byte(i < n - 1, d);
         chk8("read byte", read_exp(i), d);
      end
      u_master.stop_cond();
   endtask

   // each single-bit corruption of the own address is ignored
   task automatic bad_addr;
      logic ack;
      for (int b = 1; b < 8; b++)
      begin
         u_master.start_cond();
         u_master.put_byte({own, 1'b0} ^ (8'h01 << b), ack);
         chk1("foreign address ack", 1'b0, ack);
         u_master.put_byte(8'h00, ack);
         chk1("ignored byte ack", 1'b0, ack);
         u_master.stop_cond();
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------------
   initial
   begin
      i_nrst    = 1'b0;
      strap     = 3'h0;
      sig       = 8'h00;
      err_total = 0;
      cmp_count = 0;
      mem = '{8'h00, 8'h00, 8'hFC, 8'h00, 8'h00, 8'h00,
              8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hEF};
      void'($urandom(32'hbe6e_42ea));
      repeat (2) @(posedge i_clk);
      i_nrst <= 1'b1;
      chk_outs();
      rd_seq(12);
      $display("test 1 done");
      for (int t = 0; t < 3; t++)
      begin
         @(posedge i_clk);
         strap <= 3'($urandom);
         sig   <= 8'($urandom);
         repeat (6) @(posedge i_clk);
         bad_addr();
         wr_seq(0, 1'b1);
         wr_seq(13, 1'b1);
         chk_outs();
         wr_seq(1 + int'($urandom % 11), 1'b0);
         rd_seq(13);
         chk_outs();
         $display("test %0d done", t + 2);
      end
      wrap_up();
   end

   initial
   begin
      repeat (60000) @(posedge i_clk);
      err_total++;
      wrap_up();
   end
endmodule
